// ==== core/frst_host.sv ====
// host sequencer: resets the flash and polls its status after commands
`timescale 1ns/10ps
`default_nettype none
module frst_host
   import frst_pkg::*;
#(
   parameter int RESET_BUSY_WAIT = RESET_BUSY_WAIT_CYC,
   parameter int POLL_WAIT       = STATUS_POLL_CYC
)(
   input  wire logic         clock_in,
   input  wire logic         reset_n_in,
   input  wire logic         do_reset_in,
   input  wire logic         cmd_done_in,
   input  wire logic         suspend_in,
   input  wire logic         resume_in,
   input  wire logic         use_oe_toggle_in,
   input  wire logic         ready_busy_n_in,
   input  wire logic         general_toggle_bit_in,
   input  wire logic         erase_suspend_toggle_bit_in,
   output frst_pins_s        pins_out,
   output frst_status_s      status_out
);
   // refuse wait counts that the counters cannot hold
   if (RESET_BUSY_WAIT < 1 || RESET_BUSY_WAIT >= (1 << CNT_W))
   begin : g_bad_reset_wait
      $error("frst_host: reset wait count out of range");
   end
   if (POLL_WAIT < 1 || POLL_WAIT >= (1 << CNT_W))
   begin : g_bad_poll_wait
      $error("frst_host: poll wait count out of range");
   end
   // a busy reset may not be shorter than an idle one
   if (RESET_BUSY_WAIT < RESET_PULSE_CYC || RESET_BUSY_WAIT < RESET_IDLE_WAIT_CYC)
   begin : g_short_reset_wait
      $error("frst_host: reset wait shorter than the reset pulse");
   end

   // whole sequencer state in one register
   frst_state_s r;
   frst_state_s next_r;

   always_comb
   begin
      next_r = r;
      // done is a one-cycle pulse
      next_r.stat.done = 1'b0;
      // poll delay frozen while suspended or in flash reset
      if (r.alg_running && r.state != FRST_SUSPEND && r.state != FRST_RST_LOW && !r.poll_met)
      begin
         if (r.poll_cnt == CNT_W'(POLL_WAIT - 1))
            next_r.poll_met = 1'b1;
         else
            next_r.poll_cnt = r.poll_cnt + CNT_W'(1);
      end
      case (r.state)
         FRST_IDLE:
         begin
            next_r.pins.ce_n = 1'b1;
            next_r.pins.oe_n = 1'b1;
            if (do_reset_in)
            begin
               next_r.state = FRST_RST_LOW;
               next_r.pins.reset_n = 1'b0;
               next_r.cnt = '0;
            end
            else if (cmd_done_in)
            begin
               next_r.state = FRST_CMD_WAIT;
               next_r.alg_running = 1'b1;
               next_r.poll_met = 1'b0;
               next_r.poll_cnt = '0;
               next_r.cnt = '0;
               next_r.stat.error = 1'b0;
            end
         end

         FRST_RST_LOW:
         begin
            // hold long enough for abort of a running algorithm
            next_r.cnt = r.cnt + CNT_W'(1);
            if (r.cnt == CNT_W'(RESET_BUSY_WAIT - 1))
               next_r.stat.standby = 1'b1;
            // release once the wait for this case is served
            if ((r.alg_running && r.cnt >= CNT_W'(RESET_BUSY_WAIT - 1)) ||
                (!r.alg_running && r.cnt >= CNT_W'(RESET_IDLE_WAIT_CYC - 1) &&
                 r.cnt >= CNT_W'(RESET_PULSE_CYC - 1)))
            begin
               next_r.state = FRST_RST_HIGH;
               next_r.pins.reset_n = 1'b1;
               next_r.cnt = '0;
               next_r.alg_running = 1'b0;
               next_r.stat.busy = 1'b0;
            end
         end

         FRST_RST_HIGH:
         begin
            next_r.stat.standby = 1'b0;
            next_r.cnt = r.cnt + CNT_W'(1);
            if (r.cnt >= CNT_W'(RESET_HIGH_CYC - 1))
               next_r.state = FRST_IDLE;
         end

         FRST_CMD_WAIT:
         begin
            next_r.stat.busy = 1'b1;
            next_r.cnt = r.cnt + CNT_W'(1);
            if (r.cnt >= CNT_W'(CMD_TO_BUSY_CYC - 1))
            begin
               next_r.state = FRST_POLL_DLY;
               // flash still ready: command was not taken
               if (ready_busy_n_in)
                  next_r.stat.error = 1'b1;
            end
         end

         FRST_POLL_DLY:
         begin
            if (do_reset_in)
            begin
               next_r.state = FRST_RST_LOW;
               next_r.pins.reset_n = 1'b0;
               next_r.cnt = '0;
            end
            else if (suspend_in)
               next_r.state = FRST_SUSPEND;
            else if (ready_busy_n_in && r.poll_met)
            begin
               next_r.state = FRST_IDLE;
               next_r.alg_running = 1'b0;
               next_r.stat.busy = 1'b0;
               next_r.stat.done = 1'b1;
            end
            else if (r.poll_met)
            begin
               next_r.state = FRST_RD_LOW;
               next_r.cnt = '0;
               next_r.pins.ce_n = 1'b0;
               next_r.pins.oe_n = 1'b0;
            end
         end

         FRST_RD_LOW:
         begin
            next_r.cnt = r.cnt + CNT_W'(1);
            if (r.cnt >= CNT_W'(READ_CYC))
            begin
               // compare with previous sample of each toggle bit
               if (!r.first_rd)
               begin
                  next_r.stat.gen_toggled = general_toggle_bit_in ^ r.prev_gen;
                  next_r.stat.es_toggled  = erase_suspend_toggle_bit_in ^ r.prev_es;
               end
               next_r.prev_gen = general_toggle_bit_in;
               next_r.prev_es  = erase_suspend_toggle_bit_in;
               next_r.first_rd = 1'b0;
               // end the read with either enable
               if (use_oe_toggle_in)
                  next_r.pins.oe_n = 1'b1;
               else
               begin
                  next_r.pins.ce_n = 1'b1;
                  next_r.pins.oe_n = 1'b1;
               end
               next_r.state = FRST_RD_HIGH;
            end
         end

         FRST_RD_HIGH:
         begin
            // chip enable follows a cycle later in output-enable mode
            next_r.pins.ce_n = 1'b1;
            next_r.state = FRST_RD_DONE;
         end

         FRST_RD_DONE:
            next_r.state = FRST_POLL_DLY;

         FRST_SUSPEND:
         begin
            next_r.pins.ce_n = 1'b1;
            next_r.pins.oe_n = 1'b1;
            if (resume_in)
            begin
               // restart the poll delay only if it had not run out
               if (!r.poll_met)
                  next_r.poll_cnt = '0;
               next_r.first_rd = 1'b1;
               next_r.state = FRST_POLL_DLY;
            end
            else if (do_reset_in)
            begin
               next_r.state = FRST_RST_LOW;
               next_r.pins.reset_n = 1'b0;
               next_r.cnt = '0;
            end
         end

         default:
            next_r.state = FRST_IDLE;
      endcase
      // first read after a command only stores the toggle bits
      if (next_r.state == FRST_CMD_WAIT && r.state == FRST_IDLE)
         next_r.first_rd = 1'b1;
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         // flash pins idle high during reset
         r <= '0;
         r.state <= FRST_IDLE;
         r.pins <= '{reset_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1};
      end
      else
         r <= next_r;
   end

   assign pins_out   = r.pins;
   assign status_out = r.stat;
endmodule
`default_nettype wire

// ==== pkg/frst_pkg.sv ====
// constants and carrier types for the flash reset and status sequencer
package frst_pkg;
   localparam int CLOCK_HZ                = 10_000_000;
   localparam int RESET_READY_BUSY_NS     = 20_000;
   localparam int RESET_READY_IDLE_NS     = 500;
   localparam int RESET_PULSE_NS          = 500;
   localparam int RESET_HIGH_BEFORE_READ_NS = 50;
   localparam int CMD_TO_BUSY_DELAY_NS    = 90;
   localparam int STATUS_POLL_DELAY_NS    = 4_000;
   localparam int READ_CYCLE_NS           = 100;
   // least times round up, longest round down; only reset-high and command-to-busy are held to at least one cycle
   localparam int NS_PER_CYCLE            = 1_000_000_000 / CLOCK_HZ;
   localparam int RESET_PULSE_CYC         = (RESET_PULSE_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
   localparam int RESET_BUSY_WAIT_CYC     = (RESET_READY_BUSY_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
   localparam int RESET_IDLE_WAIT_CYC     = (RESET_READY_IDLE_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
   localparam int RESET_HIGH_CYC_RAW      = (RESET_HIGH_BEFORE_READ_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
   localparam int RESET_HIGH_CYC          = RESET_HIGH_CYC_RAW < 1 ? 1 : RESET_HIGH_CYC_RAW;
   localparam int CMD_TO_BUSY_CYC_RAW     = (CMD_TO_BUSY_DELAY_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
   localparam int CMD_TO_BUSY_CYC         = CMD_TO_BUSY_CYC_RAW < 1 ? 1 : CMD_TO_BUSY_CYC_RAW;
   localparam int STATUS_POLL_CYC         = (STATUS_POLL_DELAY_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
   localparam int READ_CYC                = READ_CYCLE_NS / NS_PER_CYCLE;
   localparam int CNT_W                   = 16;

   typedef enum logic [3:0] {
      FRST_IDLE     = 4'h0,
      FRST_RST_LOW  = 4'h1,
      FRST_RST_HIGH = 4'h3,
      FRST_CMD_WAIT = 4'h2,
      FRST_POLL_DLY = 4'h6,
      FRST_RD_LOW   = 4'h7,
      FRST_RD_HIGH  = 4'h5,
      FRST_SUSPEND  = 4'h4,
      FRST_RD_DONE  = 4'hC
   } frst_state_e;

   typedef struct packed {
      logic reset_n;
      logic ce_n;
      logic oe_n;
   } frst_pins_s;

   typedef struct packed {
      logic busy;
      logic done;
      logic error;
      logic standby;
      logic gen_toggled;
      logic es_toggled;
   } frst_status_s;

   typedef struct packed {
      frst_state_e      state;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] poll_cnt;
      logic             poll_met;
      logic             alg_running;
      logic             first_rd;
      logic             prev_gen;
      logic             prev_es;
      frst_pins_s       pins;
      frst_status_s     stat;
   } frst_state_s;
endpackage

// ==== testbench/frst_flash_model.sv ====
// behavioural flash: busy timing, reset abort and toggle bits
`timescale 1ns/10ps
`default_nettype none
module frst_flash_model
   import frst_pkg::*;
(
   input  wire logic       clock_in,
   input  wire frst_pins_s pins_in,
   input  wire logic       start_in,
   input  wire logic       es_sect_in,
   input  wire logic [7:0] alg_len_in,
   output var  logic       ready_busy_n_out,
   output wire logic       gen_out,
   output wire logic       es_out
);
   logic [7:0] left = 8'h00;
   logic       gen  = 1'b0;
   logic       es   = 1'b0;
   logic       rd_q = 1'b1;
   wire logic  rd_off = pins_in.ce_n | pins_in.oe_n;
   // released data lines show the inverse
   assign gen_out = rd_off ? ~gen : gen;
   assign es_out  = rd_off ? ~es : es;
   initial ready_busy_n_out = 1'b1;
   always @(posedge clock_in)
   begin
      rd_q <= rd_off;
      if (!pins_in.reset_n)
      begin
         left             <= 8'h00;
         ready_busy_n_out <= 1'b1;
      end
      else if (start_in)
      begin
         left             <= alg_len_in;
         ready_busy_n_out <= 1'b0;
      end
      else if (left != 8'h00)
      begin
         left             <= left - 8'h01;
         ready_busy_n_out <= left == 8'h01;
      end
      if (!rd_q && rd_off && left != 8'h00)
      begin
         gen <= ~gen;
         es  <= es ^ es_sect_in;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/frst_host_properties.sv ====
// concurrent checks on the host sequencer ports
`timescale 1ns/10ps
`default_nettype none
module frst_host_properties
   import frst_pkg::*;
#(
   parameter int RESET_BUSY_WAIT = RESET_BUSY_WAIT_CYC,
   parameter int POLL_WAIT       = STATUS_POLL_CYC
)(
   input wire logic         clock_in,
   input wire logic         reset_n_in,
   input wire logic         cmd_done_in,
   input wire logic         use_oe_toggle_in,
   input wire logic         ready_busy_n_in,
   input wire frst_pins_s   pins_out,
   input wire frst_status_s status_out
);
   logic [15:0] low_cnt;
   logic        alg;
   // length of the flash reset pulse and whether it cut an algorithm
   always_ff @(posedge clock_in or negedge reset_n_in)
      if (!reset_n_in)
      begin
         low_cnt <= 16'h0000;
         alg     <= 1'b0;
      end
      else
      begin
         low_cnt <= pins_out.reset_n ? 16'h0000 : low_cnt + 16'h0001;
         alg     <= pins_out.reset_n ? status_out.busy : alg;
      end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   property p_busy; $rose(status_out.busy) |-> $past(cmd_done_in, 2); endproperty
   a_busy: assert property (p_busy) else $error("busy without command");
   property p_err; $rose(status_out.error) |-> $past(ready_busy_n_in); endproperty
   a_err: assert property (p_err) else $error("error while flash busy");
   property p_poll; $rose(status_out.busy) |-> pins_out.oe_n [*4]; endproperty
   a_poll: assert property (p_poll) else $error("status read too early");
   property p_done; status_out.done |-> $past(ready_busy_n_in); endproperty
   a_done: assert property (p_done) else $error("done while flash busy");
   property p_rbsy; $rose(pins_out.reset_n) && alg |-> low_cnt == RESET_BUSY_WAIT; endproperty
   a_rbsy: assert property (p_rbsy) else $error("busy reset length");
   property p_ridl; $rose(pins_out.reset_n) && !alg |-> low_cnt == RESET_PULSE_CYC; endproperty
   a_ridl: assert property (p_ridl) else $error("idle reset length");
   property p_stby;
      $rose(status_out.standby) |-> $past(!pins_out.reset_n) && low_cnt >= RESET_BUSY_WAIT;
   endproperty
   a_stby: assert property (p_stby) else $error("standby too soon");
   property p_rh; $rose(pins_out.reset_n) |-> pins_out.oe_n ##1 pins_out.oe_n; endproperty
   a_rh: assert property (p_rh) else $error("read right after reset");
   property p_ce; !use_oe_toggle_in && $rose(pins_out.oe_n) |-> pins_out.ce_n; endproperty
   a_ce: assert property (p_ce) else $error("read end without chip enable");
endmodule
bind frst_host frst_host_properties #(.RESET_BUSY_WAIT(RESET_BUSY_WAIT), .POLL_WAIT(POLL_WAIT))
   i_frst_host_properties (.clock_in(clock_in), .reset_n_in(reset_n_in), .cmd_done_in(cmd_done_in),
   .use_oe_toggle_in(use_oe_toggle_in), .ready_busy_n_in(ready_busy_n_in), .pins_out(pins_out),
   .status_out(status_out));
`default_nettype wire

// ==== testbench/frst_host_tb.sv ====
// self-checking bench for the host sequencer against a flash model
`timescale 1ns/10ps
`default_nettype none
module frst_host_tb
   import frst_pkg::*;
;
   localparam int BW = 8;
   localparam int PW = 4;
   logic clock_in = 1'b0, reset_n_in = 1'b0, do_reset_in = 1'b0, cmd_done_in = 1'b0;
   logic suspend_in = 1'b0, resume_in = 1'b0, use_oe_toggle_in = 1'b0, start = 1'b0, es_sect = 1'b0;
   logic [7:0] alg_len = 8'h00;
   logic rbn, gen, es;
   frst_pins_s pins;
   frst_status_s stat;
   int errors = 0, checked = 0, cycles = 0;
   frst_host #(.RESET_BUSY_WAIT(BW), .POLL_WAIT(PW)) i_frst_host (.clock_in(clock_in),
      .reset_n_in(reset_n_in), .do_reset_in(do_reset_in), .cmd_done_in(cmd_done_in),
      .suspend_in(suspend_in), .resume_in(resume_in), .use_oe_toggle_in(use_oe_toggle_in),
      .ready_busy_n_in(rbn), .general_toggle_bit_in(gen), .erase_suspend_toggle_bit_in(es),
      .pins_out(pins), .status_out(stat));
   frst_flash_model i_frst_flash_model (.clock_in(clock_in), .pins_in(pins), .start_in(start),
      .es_sect_in(es_sect), .alg_len_in(alg_len), .ready_busy_n_out(rbn), .gen_out(gen), .es_out(es));
   initial forever #50 clock_in = ~clock_in;
   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      checked++;
      if (e !== s)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clock_in);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask
   task automatic cmd(logic st, logic [7:0] len);
      start = st;
      alg_len = len;
      pulse(cmd_done_in);
      start = 1'b0;
   endtask
   task automatic run(output int n, output logic g, output logic e);
      n = 0;
      g = 1'b0;
      e = 1'b0;
      while (stat.done !== 1'b1 && n < 300)
      begin
         cyc(1);
         n++;
         g |= stat.gen_toggled;
         e |= stat.es_toggled;
      end
   endtask
   task automatic to_read(output int n);
      n = 0;
      while (pins.oe_n !== 1'b0 && n < 100)
      begin
         cyc(1);
         n++;
      end
   endtask
   task automatic rst_len(output int n, output logic sb);
      n = 0;
      sb = 1'b0;
      do_reset_in = 1'b1;
      while (pins.reset_n !== 1'b0 && n < 100)
      begin
         cyc(1);
         n++;
      end
      do_reset_in = 1'b0;
      n = 0;
      while (pins.reset_n === 1'b0 && n < 400)
      begin
         sb |= stat.standby;
         cyc(1);
         n++;
      end
      sb |= stat.standby;
   endtask
   task automatic t_prog();
      int n;
      logic g, e;
      cmd(1'b1, 8'h14);
      cyc(1);
      chk("busy", 1, stat.busy);
      run(n, g, e);
      chk("prog_time", 1, n >= 18 && n < 300);
      chk("gen_toggled", 1, g);
      chk("es_toggled", 0, e);
      chk("error", 0, stat.error);
   endtask
   task automatic t_erase();
      int n;
      logic g, e;
      es_sect = 1'b1;
      use_oe_toggle_in = 1'b1;
      cmd(1'b1, 8'h28);
      run(n, g, e);
      chk("erase_time", 1, n >= 38 && n < 300);
      chk("es_toggled", 1, e);
      chk("gen_toggled", 1, g);
      es_sect = 1'b0;
      use_oe_toggle_in = 1'b0;
   endtask
   task automatic t_err();
      int n;
      logic g, e;
      cmd(1'b0, 8'h00);
      run(n, g, e);
      chk("error", 1, stat.error);
   endtask
   task automatic t_susp(logic late);
      int n;
      logic g, e;
      cmd(1'b1, 8'h50);
      if (late)
         to_read(n);
      else
         cyc(2);
      suspend_in = 1'b1;
      cyc(5);
      suspend_in = 1'b0;
      cyc(4);
      chk("suspended_oe_n", 1, pins.oe_n);
      pulse(resume_in);
      to_read(n);
      chk(late ? "late_wait" : "early_wait", 1, late ? n <= 2 : n >= PW && n < 100);
      run(n, g, e);
      chk("susp_done", 1, n < 300);
   endtask
   task automatic t_rst();
      int n;
      logic sb;
      cmd(1'b1, 8'h50);
      cyc(3);
      rst_len(n, sb);
      chk("busy_reset", 16'(BW), 16'(n));
      chk("standby", 1, sb);
      rst_len(n, sb);
      chk("idle_reset", 16'(RESET_PULSE_CYC), 16'(n));
      chk("standby", 0, sb);
      cyc(1);
      cmd(1'b1, 8'h50);
      cyc(3);
      pulse(suspend_in);
      rst_len(n, sb);
      chk("suspend_reset", 16'(BW), 16'(n));
      chk("standby", 1, sb);
   endtask
   initial
   begin
      cyc(8);
      reset_n_in = 1'b1;
      cyc(1);
      t_prog();
      t_erase();
      t_err();
      t_susp(1'b0);
      t_susp(1'b1);
      t_rst();
      stop_test();
   end
endmodule
`default_nettype wire
